// ---- design/spb_pkg.sv ----
package spb_pkg;

   // Bus geometry.
   localparam int SPB_NSEG = 4;
   localparam int SPB_SEG_W = 128;
   localparam int SPB_CHAN_W = 11;
   localparam int SPB_MTY_W = 4;
   localparam logic [15:0] SPB_SEG_BYTES = 16'h0010;
   localparam int SPB_WORD_SHIFT = 3;

   // Transmit flow control.
   localparam logic [3:0] SPB_WRITE_LIMIT = 4'h8;
   localparam logic [7:0] SPB_OCC_CAP = 8'h40;
   localparam logic [7:0] SPB_RDY_LEVEL = 8'h18;

   // Register byte offsets.
   localparam logic [7:0] SPB_OFF_CTRL = 8'h00;
   localparam logic [7:0] SPB_OFF_MAXB = 8'h04;
   localparam logic [7:0] SPB_OFF_SHORTB = 8'h08;
   localparam logic [7:0] SPB_OFF_MINB = 8'h0c;
   localparam logic [7:0] SPB_OFF_STAT = 8'h10;

   // Field positions.
   localparam int SPB_CTRL_MODE_BIT = 0;
   localparam int SPB_CTRL_TXRST_BIT = 1;
   localparam int SPB_STAT_RDY_BIT = 0;
   localparam int SPB_STAT_OVF_BIT = 1;
   localparam int SPB_STAT_BERR_BIT = 2;
   localparam int SPB_STAT_OCC_LSB = 8;

   // Reset values of the burst settings, in bytes.
   localparam logic [15:0] SPB_MAXB_RST = 16'h0100;
   localparam logic [15:0] SPB_SHORTB_RST = 16'h0040;
   localparam logic [15:0] SPB_MINB_RST = 16'h0040;

   typedef enum logic [0:0] {
      SPB_MODE_PACKET      = 1'b0,
      SPB_MODE_INTERLEAVED = 1'b1
   } spb_mode_e;

   typedef struct packed {
      logic                  ena;
      logic                  sop;
      logic                  eop;
      logic                  err;
      logic                  bctl;
      logic [SPB_CHAN_W-1:0] chan;
      logic [SPB_MTY_W-1:0]  mty;
      logic [SPB_SEG_W-1:0]  data;
   } spb_tx_seg_s;

   typedef struct packed {
      logic                  ena;
      logic                  sop;
      logic                  eop;
      logic                  err;
      logic [SPB_CHAN_W-1:0] chan;
      logic [SPB_MTY_W-1:0]  mty;
      logic [SPB_SEG_W-1:0]  data;
   } spb_rx_seg_s;

   typedef spb_tx_seg_s [SPB_NSEG-1:0] spb_tx_bus_t;
   typedef spb_rx_seg_s [SPB_NSEG-1:0] spb_rx_bus_t;

   typedef struct packed {
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      spb_mode_e             mode;
      logic [15:0]           max_b;
      logic [15:0]           short_b;
      logic [15:0]           min_b;
      logic                  rdy;
      logic                  ovf;
      logic                  burst_err;
      logic [7:0]            occ;
      logic [3:0]            late_wr;
      logic [15:0]           burst_cnt;
      logic [SPB_CHAN_W-1:0] last_chan;
      spb_tx_bus_t           lnk;
      logic [SPB_NSEG-1:0]   lnk_bcw;
      logic [7:0]            lnk_idle;
      logic                  lnk_valid;
      spb_rx_bus_t           rx;
   } spb_state_s;

endpackage

// ---- design/spb_rx_packer.sv ----
`timescale 1ns/1ns
module spb_rx_packer
   import spb_pkg::*;
(
   // Receive segments as delivered by the link decoder.
   input  wire spb_rx_bus_t in_bus,
   // Cleaned segments, packed from segment 0 upward.
   output spb_rx_bus_t      out_bus
);

   // Clean one segment: nothing but zeros unless enabled, and the error
   // and empty count only carry meaning on the segment that ends a packet.
   function automatic spb_rx_seg_s clean(input spb_rx_seg_s s);
      spb_rx_seg_s c;
      c = s;
      if (!s.ena) begin
         c = '0;
      end else if (!s.eop) begin
         c.err = 1'b0;
         c.mty = '0;
      end
      return c;
   endfunction

   // Select the k-th enabled input segment, keeping arrival order.
   function automatic spb_rx_seg_s pick(input spb_rx_bus_t b, input logic [2:0] k);
      spb_rx_seg_s r;
      logic [2:0]  cnt;
      r = '0;
      cnt = 3'h0;
      for (int j = 0; j < SPB_NSEG; j++) begin
         if (b[j].ena) begin
            if (cnt == k) begin
               r = clean(b[j]);
            end
            cnt = cnt + 3'h1;
         end
      end
      return r;
   endfunction

   // Gaps in the decoder output are squeezed out so that active segments
   // always start at segment 0; several starts or ends may share a cycle.
   for (genvar k = 0; k < SPB_NSEG; k++) begin : g_slot
      assign out_bus[k] = pick(in_bus, 3'(k));
   end

endmodule

// ---- design/spb_core.sv ----
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module spb_core
   import spb_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // APB register port.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Transmit side of the segmented local bus.
   input  wire spb_tx_bus_t tx_bus,
   output logic             tx_rdy,
   output logic             tx_ovf,
   // Framed transmit stream toward the link, and its drain strobe.
   input  wire logic        link_take,
   output spb_tx_bus_t      link_tx_bus,
   output logic [3:0]       link_tx_bcw,
   output logic [7:0]       link_tx_idle,
   output logic             link_tx_valid,
   output logic             tx_burst_err,
   // Receive side: decoder input and segmented local bus output.
   input  wire spb_rx_bus_t link_rx_bus,
   output spb_rx_bus_t      rx_bus
);

   spb_state_s  st_r;
   spb_state_s  st_nxt;
   spb_rx_bus_t rx_packed;

   ////////////////////////////////////////////////////////////////////////////
   // Receive packing.

   // The packer is purely combinational; its result is registered below.
   spb_rx_packer u_packer (
      .in_bus  (link_rx_bus),
      .out_bus (rx_packed)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Register port, transmit flow control and burst framing in one pass.
   always_comb begin
      logic        wr;
      logic        txrst;
      logic        ovf_set;
      logic        berr_set;
      logic [31:0] rdata;
      logic        unmapped;
      logic [15:0] bc;
      logic [15:0] tgt;
      logic [SPB_CHAN_W-1:0] ch;
      logic [2:0]  nb;
      logic [7:0]  idle;
      logic [3:0]  bcw;
      logic [2:0]  nseg;
      logic [2:0]  drained;
      logic [8:0]  occ_sum;
      logic        bound;
      logic        ena0;
      wr = 1'b0;
      txrst = 1'b0;
      ovf_set = 1'b0;
      berr_set = 1'b0;
      rdata = 32'h0000_0000;
      unmapped = 1'b0;
      bc = st_r.burst_cnt;
      tgt = 16'h0000;
      ch = st_r.last_chan;
      nb = 3'h0;
      idle = 8'h00;
      bcw = 4'h0;
      nseg = 3'h0;
      drained = 3'h0;
      occ_sum = 9'h000;
      bound = 1'b0;
      ena0 = tx_bus[0].ena;
      st_nxt = st_r;

      // Register read decode happens in the setup phase so that the answer
      // is already standing from a flop when the access phase begins.
      if (paddr == SPB_OFF_CTRL) begin
         rdata[SPB_CTRL_MODE_BIT] = st_r.mode;
      end else if (paddr == SPB_OFF_MAXB) begin
         rdata[15:0] = st_r.max_b;
      end else if (paddr == SPB_OFF_SHORTB) begin
         rdata[15:0] = st_r.short_b;
      end else if (paddr == SPB_OFF_MINB) begin
         rdata[15:0] = st_r.min_b;
      end else if (paddr == SPB_OFF_STAT) begin
         rdata[SPB_STAT_RDY_BIT] = st_r.rdy;
         rdata[SPB_STAT_OVF_BIT] = st_r.ovf;
         rdata[SPB_STAT_BERR_BIT] = st_r.burst_err;
         rdata[SPB_STAT_OCC_LSB +: 8] = st_r.occ;
      end else begin
         unmapped = 1'b1;
      end

      if (psel && !penable) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = unmapped;
         st_nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
      end else begin
         st_nxt.pready = 1'b0;
         st_nxt.pslverr = 1'b0;
      end

      // A write lands only at the access edge that sees pready high.
      wr = psel && penable && pwrite && st_r.pready && !st_r.pslverr;
      if (wr && paddr == SPB_OFF_CTRL) begin
         st_nxt.mode = spb_mode_e'(pwdata[SPB_CTRL_MODE_BIT]);
         txrst = pwdata[SPB_CTRL_TXRST_BIT];
      end else if (wr && paddr == SPB_OFF_MAXB) begin
         st_nxt.max_b = pwdata[15:0];
      end else if (wr && paddr == SPB_OFF_SHORTB) begin
         st_nxt.short_b = pwdata[15:0];
      end else if (wr && paddr == SPB_OFF_MINB) begin
         st_nxt.min_b = pwdata[15:0];
      end

      // Burst framing: a control word opens a burst at a start, a forced
      // boundary, a channel change in interleaved mode, or when the next
      // segment would run past the maximum burst size. Short bursts are
      // padded with idle words, which costs bandwidth but keeps the link
      // partner's burst settings intact.
      for (int i = 0; i < SPB_NSEG; i++) begin
         if (ena0 && tx_bus[i].ena) begin
            nseg = nseg + 3'h1;
            bound = tx_bus[i].sop || tx_bus[i].bctl || (bc == 16'h0000)
                    || (bc + SPB_SEG_BYTES > st_r.max_b);
            if (st_r.mode == SPB_MODE_INTERLEAVED && tx_bus[i].chan != ch) begin
               bound = 1'b1;
            end
            if (bound) begin
               if (bc != 16'h0000 && bc < st_r.short_b) begin
                  idle = idle + 8'((st_r.short_b - bc) >> SPB_WORD_SHIFT);
               end
               bcw[i] = 1'b1;
               nb = nb + 3'h1;
               bc = SPB_SEG_BYTES;
            end else begin
               bc = bc + SPB_SEG_BYTES;
            end
            ch = tx_bus[i].chan;
            if (tx_bus[i].eop) begin
               // The closing burst is stretched to the larger of the short
               // and minimum sizes with idle words.
               tgt = (st_r.short_b > st_r.min_b) ? st_r.short_b : st_r.min_b;
               if (bc < tgt) begin
                  idle = idle + 8'((tgt - bc) >> SPB_WORD_SHIFT);
               end
               bc = 16'h0000;
            end
         end
      end
      berr_set = (nb > 3'h1);

      // Occupancy of the transmit store, drained by the link in groups of
      // up to one bus width per strobe.
      if (link_take) begin
         drained = (st_r.occ >= 8'(SPB_NSEG)) ? 3'(SPB_NSEG) : st_r.occ[2:0];
      end
      occ_sum = {1'b0, st_r.occ} - {6'h00, drained} + {6'h00, nseg};
      if (occ_sum > {1'b0, SPB_OCC_CAP}) begin
         ovf_set = 1'b1;
         occ_sum = {1'b0, SPB_OCC_CAP};
      end

      // Writes made while ready is low are counted; the ninth is a breach.
      if (st_r.rdy) begin
         st_nxt.late_wr = 4'h0;
      end else if (ena0) begin
         if (st_r.late_wr == SPB_WRITE_LIMIT) begin
            ovf_set = 1'b1;
         end else begin
            st_nxt.late_wr = st_r.late_wr + 4'h1;
         end
      end

      st_nxt.occ = occ_sum[7:0];
      st_nxt.burst_cnt = bc;
      st_nxt.last_chan = ch;
      if (txrst) begin
         st_nxt.occ = 8'h00;
         st_nxt.late_wr = 4'h0;
         st_nxt.burst_cnt = 16'h0000;
      end
      // Ready leaves room for eight full late writes above its level.
      st_nxt.rdy = (st_nxt.occ <= SPB_RDY_LEVEL);
      // A new event wins over a clear arriving in the same cycle.
      st_nxt.ovf = ovf_set || (st_r.ovf && !txrst);
      st_nxt.burst_err = berr_set || (st_r.burst_err && !txrst);

      st_nxt.lnk = tx_bus;
      st_nxt.lnk_bcw = bcw;
      st_nxt.lnk_idle = idle;
      st_nxt.lnk_valid = ena0;
      if (!ena0) begin
         st_nxt.lnk = '0;
      end
      st_nxt.rx = rx_packed;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   // The clock enable freezes every flop, the register port included.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.max_b <= SPB_MAXB_RST;
         st_r.short_b <= SPB_SHORTB_RST;
         st_r.min_b <= SPB_MINB_RST;
         st_r.rdy <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Every output is taken straight from the state register.
   assign prdata        = st_r.prdata;
   assign pready        = st_r.pready;
   assign pslverr       = st_r.pslverr;
   assign tx_rdy        = st_r.rdy;
   assign tx_ovf        = st_r.ovf;
   assign link_tx_bus   = st_r.lnk;
   assign link_tx_bcw   = st_r.lnk_bcw;
   assign link_tx_idle  = st_r.lnk_idle;
   assign link_tx_valid = st_r.lnk_valid;
   assign tx_burst_err  = st_r.burst_err;
   assign rx_bus        = st_r.rx;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic [3:0] rx_ena_out;
   logic [3:0] rx_ena_in;
   for (genvar g = 0; g < SPB_NSEG; g++) begin : g_ena
      assign rx_ena_out[g] = st_r.rx[g].ena;
      assign rx_ena_in[g] = link_rx_bus[g].ena;
   end

   AST_OVF_NINTH: assert property (@(posedge pclk) disable iff (!presetn)
      ce && tx_bus[0].ena && !st_r.rdy && st_r.late_wr == 4'h8 |=> st_r.ovf)
      else $error("ninth late write did not raise overflow");

   AST_LATE_SAFE: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !st_r.ovf && st_r.late_wr < 4'h8 && tx_bus[0].ena
      && st_r.occ <= 8'h24 && !link_take |=> !st_r.ovf)
      else $error("overflow raised within the allowed late writes");

   AST_SOP_BCW: assert property (@(posedge pclk) disable iff (!presetn)
      ce && tx_bus[0].ena && tx_bus[0].sop |=> link_tx_bcw[0] && link_tx_valid)
      else $error("start of packet did not open a burst");

   AST_BCTL_BCW: assert property (@(posedge pclk) disable iff (!presetn)
      ce && tx_bus[0].ena && tx_bus[2].ena && tx_bus[2].bctl |=> link_tx_bcw[2])
      else $error("forced boundary did not insert a control word");

   AST_MAX_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.max_b >= 16'h0010 && $stable(st_r.max_b) |-> st_r.burst_cnt <= st_r.max_b)
      else $error("burst ran past the maximum burst size");

   AST_EOP_PAD: assert property (@(posedge pclk) disable iff (!presetn)
      ce && st_r.burst_cnt == 16'h0000 && tx_bus[0].ena && tx_bus[0].sop
      && tx_bus[0].eop && !tx_bus[1].ena && st_r.min_b == 16'h0040
      && st_r.short_b == 16'h0040 |=> link_tx_idle == 8'h06)
      else $error("single segment packet not padded to six idle words");

   AST_RX_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
      !st_r.rx[1].ena |-> st_r.rx[1] == '0)
      else $error("disabled receive segment carries stray values");

   AST_RX_CONTIG: assert property (@(posedge pclk) disable iff (!presetn)
      rx_ena_out inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
      else $error("receive segments not contiguous from segment 0");

   AST_RX_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> $countones(rx_ena_out) == $countones($past(rx_ena_in)))
      else $error("receive segment lost or duplicated");

   AST_RX_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.rx[0].err |-> st_r.rx[0].eop && st_r.rx[0].ena)
      else $error("receive error without end of packet");

endmodule

// ---- dv/spb_link_partner.sv ----
`timescale 1ns/1ns
module spb_link_partner
   import spb_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Bench control.
   input  wire logic        stall,
   // Receive bus from the device.
   input  wire spb_rx_bus_t rx_bus,
   // Drain strobe and receive tally.
   output logic             link_take,
   output logic [15:0]      rx_seen
);
   ////////////////////////////////////////////////////////////////////////////////
   // The drain follows the stall request one edge late, as a slow serial side would.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_take <= 1'b0;
      end else begin
         link_take <= !stall;
      end
   end

   // Every enabled segment is taken in the cycle it shows; the sink never stalls.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_seen <= 16'h0000;
      end else begin
         rx_seen <= rx_seen + 16'($countones({rx_bus[3].ena, rx_bus[2].ena,
                                              rx_bus[1].ena, rx_bus[0].ena}));
      end
   end
endmodule

// ---- dv/tb_segmented_packet_bus_bursting.sv ----
`timescale 1ns/1ns
module tb_segmented_packet_bus_bursting;
   import spb_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, rerr, stall = 1'b0;
   logic        ce = 1'b1;
   spb_tx_bus_t tx_bus = '0;
   spb_tx_bus_t link_tx_bus, b;
   spb_rx_bus_t link_rx_bus = '0;
   spb_rx_bus_t rx_bus, e;
   logic        tx_rdy, tx_ovf, link_take, link_tx_valid, tx_burst_err;
   logic [3:0]  link_tx_bcw;
   logic [7:0]  link_tx_idle;
   logic [15:0] rx_seen;
   int          err_count = 0;
   int          comparisons = 0;
   int          nrx = 0;
   int          j;
   // Row: mode, ena, sop, eop, bctl, channel-one mask, expected bcw, idle (ff: skip).
   logic [32:0] txr [16] = '{
      {1'b0,20'h11100,4'h1,8'h06}, {1'b0,20'hf1800,4'h1,8'h00}, {1'b0,20'hf1000,4'h1,8'h00},
      {1'b0,20'hf0000,4'h0,8'h00}, {1'b0,20'hf0000,4'h0,8'h00}, {1'b0,20'hf0000,4'h0,8'h00},
      {1'b0,20'h10100,4'h1,8'h06}, {1'b0,20'hf1000,4'h1,8'h00}, {1'b0,20'hf0040,4'h4,8'h00},
      {1'b0,20'h30200,4'h0,8'h00}, {1'b1,20'hf1000,4'h1,8'h00}, {1'b1,20'hf400c,4'h4,8'h00},
      {1'b1,20'hf0000,4'h1,8'h04}, {1'b1,20'h30302,4'h2,8'hff}, {1'b0,20'hf1040,4'h5,8'hff},
      {1'b0,20'h10100,4'h0,8'h02}};
   // Row: ena, sop, eop, err of the decoder segments.
   logic [15:0] rxr [5] = '{16'ha222, 16'hf5a0, 16'h0000, 16'h4044, 16'h9991};

   spb_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_bus(tx_bus), .tx_rdy(tx_rdy), .tx_ovf(tx_ovf),
      .link_take(link_take), .link_tx_bus(link_tx_bus), .link_tx_bcw(link_tx_bcw),
      .link_tx_idle(link_tx_idle), .link_tx_valid(link_tx_valid),
      .tx_burst_err(tx_burst_err), .link_rx_bus(link_rx_bus), .rx_bus(rx_bus));

   spb_link_partner partner (.pclk(pclk), .presetn(presetn), .stall(stall), .rx_bus(rx_bus),
      .link_take(link_take), .rx_seen(rx_seen));

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison and closing tasks.
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_tx(input spb_tx_bus_t got, input spb_tx_bus_t exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s mismatch", $time, m);
      end
   endtask

   task automatic chk_rx(input spb_rx_bus_t got, input spb_rx_bus_t exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s mismatch", $time, m);
      end
   endtask

   task automatic results;
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // APB master: request held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: only the watchdog may end a wait that never answers.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One transmit write, then the bus returns to zero and 1 ns passes so the result has settled.
   task automatic tx_send(input spb_tx_bus_t x);
      @(posedge pclk);
      tx_bus <= x;
      @(posedge pclk);
      tx_bus <= '0;
      #1;
   endtask

   // Segments are filled from 0 upward and all carry full data, with an empty count of zero even where they end a packet.
   function automatic spb_tx_bus_t mk(input logic [19:0] r);
      spb_tx_bus_t x;
      x = '0;
      for (int i = 0; i < SPB_NSEG; i++) begin
         if (r[16+i]) begin
            x[i].ena = 1'b1;
            x[i].sop = r[12+i];
            x[i].eop = r[8+i];
            x[i].bctl = r[4+i];
            x[i].chan = {10'h000, r[i]};
            x[i].data = {16{8'(i + 1)}};
         end
      end
      return x;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, reset and watchdog.
   initial begin
      forever #25 pclk = ~pclk;
   end

   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      results;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, a read-only status word and an unmapped word.
      for (int k = 0; k < 6; k++) begin
         apb(1'b0, 8'(4 * k), 32'h0);
         chk_v(rdat, k == 1 ? 32'h100 : (k == 2 || k == 3) ? 32'h40 : k == 4 ? 32'h1 : 32'h0,
               "reset read");
         chk_v(rerr, k == 5, "slave error");
      end
      apb(1'b1, SPB_OFF_STAT, 32'hffffffff);
      apb(1'b0, SPB_OFF_STAT, 32'h0);
      chk_v(rdat, 32'h1, "status read-only");
      stall <= 1'b0;
      // Receive rows: enabled inputs land packed from segment 0 in order.
      foreach (rxr[k]) begin
         e = '0;
         b = '0;
         j = 0;
         for (int i = 0; i < SPB_NSEG; i++) begin
            if (rxr[k][12+i]) begin
               e[j].ena = 1'b1;
               e[j].sop = rxr[k][8+i];
               e[j].eop = rxr[k][4+i];
               e[j].err = rxr[k][i];
               e[j].chan = 11'(i + 3);
               e[j].mty = rxr[k][4+i] ? 4'(i + 1) : 4'h0;
               e[j].data = {16{8'(17 * (i + 1))}};
               j++;
            end
         end
         nrx += j;
         @(posedge pclk);
         j = 0;
         for (int i = 0; i < SPB_NSEG; i++) begin
            if (rxr[k][12+i]) begin
               link_rx_bus[i] <= e[j];
               j++;
            end else begin
               link_rx_bus[i] <= '0;
            end
         end
         @(posedge pclk);
         link_rx_bus <= '0;
         #1;
         chk_rx(rx_bus, e, "rx segments");
      end
      // The sink tallies the last row at the edge after it is shown.
      @(posedge pclk);
      #1;
      chk_v(rx_seen, 32'(nrx), "rx tally");
      // Transmit rows, draining freely.
      repeat (3) @(posedge pclk);
      foreach (txr[k]) begin
         apb(1'b1, SPB_OFF_CTRL, {31'h0, txr[k][32]});
         b = mk(txr[k][31:12]);
         tx_send(b);
         chk_tx(link_tx_bus, b, "tx copy");
         chk_v(link_tx_valid, 32'h1, "tx valid");
         chk_v(link_tx_bcw, txr[k][11:8], "control words");
         if (txr[k][7:0] != 8'hff) begin
            chk_v(link_tx_idle, txr[k][7:0], "idle words");
         end
      end
      chk_v(tx_burst_err, 32'h1, "burst error");
      apb(1'b1, SPB_OFF_CTRL, 32'h2);
      #1;
      chk_v(tx_burst_err, 32'h0, "burst error clear");
      // A smaller maximum burst moves the implied boundary.
      apb(1'b1, SPB_OFF_MAXB, 32'h80);
      apb(1'b0, SPB_OFF_MAXB, 32'h0);
      chk_v(rdat, 32'h80, "max readback");
      for (int k = 0; k < 3; k++) begin
         tx_send(mk({4'hf, k == 0 ? 4'h1 : 4'h0, 12'h000}));
         chk_v(link_tx_bcw, k == 1 ? 4'h0 : 4'h1, "max boundary");
      end
      tx_send(mk(20'h10100));
      // Stalled drain: ready drops, eight late writes pass, the ninth overflows.
      @(posedge pclk);
      stall <= 1'b1;
      repeat (4) @(posedge pclk);
      for (int k = 1; k <= 16; k++) begin
         tx_send(mk(20'hf1800));
         chk_v(tx_rdy, k <= 6, "tx ready");
         chk_v(tx_ovf, k == 16, "tx overflow");
      end
      apb(1'b0, SPB_OFF_STAT, 32'h0);
      chk_v(rdat[15:0], 16'h4002, "status");
      // Reset in mid-run clears flags and settings; the writer stops first.
      @(posedge pclk);
      presetn <= 1'b0;
      stall <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk_v(tx_ovf, 32'h0, "ovf after reset");
      chk_v(tx_rdy, 32'h1, "rdy after reset");
      apb(1'b0, SPB_OFF_MAXB, 32'h0);
      chk_v(rdat, 32'h100, "max after reset");
      // A low clock enable must hold every flop, so a write made then is lost.
      ce <= 1'b0;
      tx_send(mk(20'h11100));
      chk_v(link_tx_valid, 32'h0, "frozen valid");
      @(posedge pclk);
      ce <= 1'b1;
      tx_send(mk(20'h11100));
      chk_v(link_tx_valid, 32'h1, "resumed valid");
      chk_v(link_tx_idle, 32'h6, "resumed idle words");
      results;
   end
endmodule
